/* hw/log_synced_output_scheduler.v */
// Output scheduler around periodic logging instants
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "sched_regs.vh"
module log_synced_output_scheduler #(
	parameter [26:0] SEC_CYCLES = `SEC_CYCLES
) (
	input  wire        CLK_I,
	input  wire        RST_I,
	input  wire [3:0]  ADDR_I,
	input  wire [15:0] WDATA_I,
	input  wire        WR_I,
	input  wire        RD_I,
	input  wire        TRIG_I,
	output reg  [15:0] RDATA_O,
	output reg         CONTACT_CLOSED_O,
	output wire        LOG_INSTANT_O
);
	reg  [1:0]  top_mode_reg;
	reg  [11:0] out_cfg_reg;
	reg  [15:0] pre_reg;
	reg  [15:0] post_reg;
	reg  [15:0] log_reg;
	reg  [15:0] trig_len_reg;
	reg  [15:0] to_log_reg;
	reg  [15:0] post_cnt_reg;
	reg  [15:0] trig_cnt_reg;
	reg  [7:0]  div_cnt_reg;
	reg         trig_s1_reg;
	reg         trig_s2_reg;
	reg         trig_s3_reg;
	reg         log_tick_reg;
	reg         active_reg;
	reg  [15:0] to_log_next;
	reg  [15:0] post_cnt_next;
	reg  [15:0] trig_cnt_next;
	reg  [7:0]  div_cnt_next;
	wire        sec_tick;
	wire [1:0]  out_mode;
	wire        pol_closed;
	wire [7:0]  divider;
	wire        selected;
	wire        in_pre;
	wire        trig_rise;
	wire        window_on;
	wire        active_next;
	wire        log_due;

	assign out_mode   = out_cfg_reg[`CFG_MODE_LSB +: 2];
	assign pol_closed = out_cfg_reg[`CFG_POL_BIT];
	assign divider    = out_cfg_reg[`CFG_DIV_LSB +: `DIV_W];
	assign LOG_INSTANT_O = log_tick_reg;

	sec_tick #(
		.CYCLES(SEC_CYCLES)
	) u_sec (
		.clk_i (CLK_I),
		.rst_i (RST_I),
		.tick_o(sec_tick)
	);

	// =================================================================
	// Register bus
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			top_mode_reg <= `RST_TOP_MODE;
			out_cfg_reg  <= `RST_OUT_CFG;
			pre_reg      <= `RST_PRE_SECS;
			post_reg     <= `RST_POST_SECS;
			log_reg      <= `RST_LOG_SECS;
			trig_len_reg <= `RST_TRIG_SECS;
		end else if (WR_I) begin
			case (ADDR_I)
			`REG_TOP_MODE:  top_mode_reg <= WDATA_I[1:0];
			`REG_OUT_CFG:   out_cfg_reg  <= WDATA_I[11:0];
			`REG_PRE_SECS:  pre_reg      <= WDATA_I;
			`REG_POST_SECS: post_reg     <= WDATA_I;
			`REG_LOG_SECS:  log_reg      <= WDATA_I;
			`REG_TRIG_SECS: trig_len_reg <= WDATA_I;
			default: ;
			endcase
		end
	end

	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			RDATA_O <= 16'h0000;
		end else if (RD_I) begin
			case (ADDR_I)
			`REG_TOP_MODE:  RDATA_O <= {14'h0000, top_mode_reg};
			`REG_OUT_CFG:   RDATA_O <= {4'h0, out_cfg_reg};
			`REG_PRE_SECS:  RDATA_O <= pre_reg;
			`REG_POST_SECS: RDATA_O <= post_reg;
			`REG_LOG_SECS:  RDATA_O <= log_reg;
			`REG_TRIG_SECS: RDATA_O <= trig_len_reg;
			`REG_STATUS:    RDATA_O <= {14'h0000, trig_cnt_reg != 16'h0000,
				active_reg};
			`REG_DIV_COUNT: RDATA_O <= {8'h00, div_cnt_reg};
			default:        RDATA_O <= 16'h0000;
			endcase
		end else begin
			RDATA_O <= 16'h0000;
		end
	end

	// =================================================================
	// Trigger input synchroniser
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_s3_reg <= 1'b0;
		end else begin
			trig_s1_reg <= TRIG_I;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end
	assign trig_rise = trig_s2_reg & ~trig_s3_reg;

	// =================================================================
	// Log interval, divider, post and trigger timers
	// Divider of zero treated as one; a count left past N-1 by a
	// divider change still selects, so a smaller N never stalls
	assign selected = (divider <= `DIV_ONE) ||
		(div_cnt_reg >= divider - `DIV_ONE);
	assign in_pre = (to_log_reg <= pre_reg) &&
		(pre_reg != `SECS_ZERO) &&
		(selected || out_mode == `OUT_MODE_SERIAL);
	assign log_due = sec_tick && (to_log_reg <= `SECS_ONE);

	always @* begin
		to_log_next   = to_log_reg;
		div_cnt_next  = div_cnt_reg;
		post_cnt_next = post_cnt_reg;
		trig_cnt_next = trig_cnt_reg;
		if (log_due) begin
			// Logging instant reached
			to_log_next = log_reg;
			if (selected)
				div_cnt_next = `DIV_ZERO;
			else
				div_cnt_next = div_cnt_reg + `DIV_ONE;
			if (out_mode == `OUT_MODE_PRE && selected)
				post_cnt_next = post_reg;
			else
				post_cnt_next = `SECS_ZERO;
		end else if (sec_tick) begin
			to_log_next = to_log_reg - `SECS_ONE;
			if (post_cnt_reg != `SECS_ZERO)
				post_cnt_next = post_cnt_reg - `SECS_ONE;
		end
		// A new trigger edge restarts the drive time
		if (trig_rise)
			trig_cnt_next = trig_len_reg;
		else if (sec_tick && trig_cnt_reg != `SECS_ZERO)
			trig_cnt_next = trig_cnt_reg - `SECS_ONE;
	end

	// Countdown to the next logging instant
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			to_log_reg   <= `RST_LOG_SECS;
			log_tick_reg <= 1'b0;
		end else begin
			to_log_reg   <= to_log_next;
			log_tick_reg <= log_due;
		end
	end

	// Position among logging instants for the divider
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			div_cnt_reg <= `DIV_ZERO;
		end else begin
			div_cnt_reg <= div_cnt_next;
		end
	end

	// Post-sample hold timer
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			post_cnt_reg <= `SECS_ZERO;
		end else begin
			post_cnt_reg <= post_cnt_next;
		end
	end

	// Fixed-time trigger drive timer
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			trig_cnt_reg <= `SECS_ZERO;
		end else begin
			trig_cnt_reg <= trig_cnt_next;
		end
	end

	// =================================================================
	// Output drive
	assign window_on = (out_mode == `OUT_MODE_PRE ||
		out_mode == `OUT_MODE_SERIAL) &&
		(in_pre || post_cnt_reg != 16'h0000);
	assign active_next = (top_mode_reg == `TOP_ADV) &&
		(window_on || trig_cnt_reg != 16'h0000);

	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			active_reg       <= 1'b0;
			CONTACT_CLOSED_O <= `RST_CONTACT;
		end else begin
			active_reg       <= active_next;
			CONTACT_CLOSED_O <= active_next ~^ pol_closed;
		end
	end
endmodule // log_synced_output_scheduler

/* hw/sched_regs.vh */
// Register offsets, field positions and timing constants of the scheduler
`ifndef SCHED_REGS_VH
`define SCHED_REGS_VH

// =====================================================================
// Register offsets (word addresses)
`define ADDR_W           4
`define REG_TOP_MODE     4'h0
`define REG_OUT_CFG      4'h1
`define REG_PRE_SECS     4'h2
`define REG_POST_SECS    4'h3
`define REG_LOG_SECS     4'h4
`define REG_TRIG_SECS    4'h5
`define REG_STATUS       4'h6
`define REG_DIV_COUNT    4'h7

// =====================================================================
// Fields and encodings
`define TOP_OFF          2'h0
`define TOP_ADV          2'h1
`define OUT_MODE_OFF     2'h0
`define OUT_MODE_PRE     2'h1
`define OUT_MODE_SERIAL  2'h2
`define CFG_MODE_LSB     0
`define CFG_POL_BIT      2
`define CFG_DIV_LSB      4
`define DIV_W            8
`define SECS_W           16
`define DIV_ONE          8'h01
`define DIV_ZERO         8'h00
`define SECS_ZERO        16'h0000
`define SECS_ONE         16'h0001

// =====================================================================
// Reset values
`define RST_TOP_MODE     2'h0
`define RST_OUT_CFG      12'h010
`define RST_PRE_SECS     16'h000a
`define RST_POST_SECS    16'h0005
`define RST_LOG_SECS     16'h012c
`define RST_TRIG_SECS    16'h001e
// Inactive contact level for the reset polarity (open is active)
`define RST_CONTACT      1'b1

// =====================================================================
// Timing: one second tick from a 100 MHz clock
`define CLK_PERIOD_NS    10
`define SEC_CYCLES       27'd100000000
`define PRESC_W          27

`endif

/* hw/sec_tick.v */
// One-second tick generator
`timescale 1ns/1ns
`include "sched_regs.vh"
module sec_tick #(
	parameter [26:0] CYCLES = `SEC_CYCLES
) (
	input  wire clk_i,
	input  wire rst_i,
	output reg  tick_o
);
	reg [26:0] cnt_reg;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= 27'h0;
			tick_o  <= 1'b0;
		end else if (cnt_reg == CYCLES - 27'h1) begin
			cnt_reg <= 27'h0;
			tick_o  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 27'h1;
			tick_o  <= 1'b0;
		end
	end
endmodule // sec_tick

/* verification/contact_load.sv */
// Far-side equipment model: counts contact closures
`timescale 1ns/1ns
module contact_load (
	input	wire		clk_i,
	input	wire		contact_i,
	output	reg	[7:0]	closures_o
);
reg	last_reg;
initial closures_o = 8'h00;
always @(posedge clk_i) begin
	if (contact_i === 1'b1 && last_reg !== 1'b1)
		closures_o <= closures_o + 8'h01;
	last_reg <= contact_i;
end
endmodule // contact_load

/* verification/log_synced_output_scheduler_bench.sv */
// Self-checking bench for the output scheduler
`timescale 1ns/1ns
module log_synced_output_scheduler_bench;
reg		CLK_I = 0;
reg		RST_I = 0;
reg	[3:0]	ADDR_I = 0;
reg	[15:0]	WDATA_I = 0;
reg		WR_I = 0;
reg		RD_I = 0;
reg		TRIG_I = 0;
wire	[15:0]	RDATA_O;
wire		CONTACT_CLOSED_O;
wire		LOG_INSTANT_O;
wire	[7:0]	closures;
int		n_mismatch = 0;
int		compares = 0;
time		t0;
reg	[15:0]	rv [0:7] = '{16'h0000, 16'h0010, 16'h000a, 16'h0005,
	16'h012c, 16'h001e, 16'h0000, 16'h0000};
log_synced_output_scheduler #(.SEC_CYCLES(27'd4)) DUT (.CLK_I(CLK_I),
	.RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
	.RD_I(RD_I), .TRIG_I(TRIG_I), .RDATA_O(RDATA_O),
	.CONTACT_CLOSED_O(CONTACT_CLOSED_O), .LOG_INSTANT_O(LOG_INSTANT_O));
contact_load load (.clk_i(CLK_I), .contact_i(CONTACT_CLOSED_O),
	.closures_o(closures));
initial forever #5 CLK_I = ~CLK_I;
initial begin
	#400000;
	n_mismatch++;
	print_verdict;
end
task chk(input string n, input [15:0] s, input [15:0] e);
	compares++;
	if (s !== e) begin
		n_mismatch++;
		$display("[FAIL] %s expected %h seen %h", n, e, s);
	end
endtask
task wr(input [3:0] a, input [15:0] d);
	@(posedge CLK_I);
	ADDR_I <= a;
	WDATA_I <= d;
	WR_I <= 1'b1;
	@(posedge CLK_I);
	WR_I <= 1'b0;
endtask
task rd(input [3:0] a, input [15:0] e);
	@(posedge CLK_I);
	ADDR_I <= a;
	RD_I <= 1'b1;
	@(posedge CLK_I);
	RD_I <= 1'b0;
	@(negedge CLK_I);
	chk("read data", RDATA_O, e);
endtask
task inst(input int n);
	repeat (n) begin
		@(posedge CLK_I);
		while (LOG_INSTANT_O !== 1'b1) @(posedge CLK_I);
	end
endtask
// Closures seen over n log instants
task win(input int n, input [7:0] e);
	reg [7:0] c0;
	inst(1);
	c0 = closures;
	inst(n);
	chk("closures", closures - c0, e);
endtask
task print_verdict;
	$display("compares %0d mismatches %0d", compares, n_mismatch);
	if (n_mismatch == 0 && compares > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
initial begin
	// Rising edge fires the asynchronous reset
	RST_I <= 1'b1;
	repeat (8) @(posedge CLK_I);
	RST_I <= 1'b0;
	for (int i = 0; i < 8; i++)
		rd(4'(i), rv[i]);
	rd(4'hf, 16'h0000);
	chk("idle contact", CONTACT_CLOSED_O, 1);
	wr(4'h1, 16'h0015);
	wr(4'h2, 16'h0002);
	wr(4'h3, 16'h0001);
	wr(4'h4, 16'h0008);
	wr(4'h5, 16'h0003);
	win(2, 0);
	chk("off contact", CONTACT_CLOSED_O, 0);
	wr(4'h0, 16'h0001);
	win(3, 3);
	t0 = $time;
	inst(1);
	chk("log period", 16'(($time - t0) / 10), 16'd32);
	wr(4'h1, 16'h0035);
	win(6, 2);
	rd(4'h7, 16'h0001);
	wr(4'h1, 16'h0036);
	win(3, 3);
	wr(4'h1, 16'h0004);
	TRIG_I <= 1'b1;
	repeat (4) @(posedge CLK_I);
	TRIG_I <= 1'b0;
	rd(4'h6, 16'h0003);
	chk("trig contact", CONTACT_CLOSED_O, 1);
	repeat (20) @(posedge CLK_I);
	chk("trig end", CONTACT_CLOSED_O, 0);
	print_verdict;
end
endmodule // log_synced_output_scheduler_bench

/* verification/sched_checker.sv */
// Port assertions for the output scheduler
`timescale 1ns/1ns
module sched_checker #(parameter [26:0] SEC_CYCLES = 27'd4) (
	input	wire		CLK_I,
	input	wire		RST_I,
	input	wire	[3:0]	ADDR_I,
	input	wire	[15:0]	WDATA_I,
	input	wire		WR_I,
	input	wire		RD_I,
	input	wire		TRIG_I,
	input	wire	[15:0]	RDATA_O,
	input	wire		CONTACT_CLOSED_O,
	input	wire		LOG_INSTANT_O
);
// =====
// Shadow of configuration writes
reg	[11:0]	cfg_q;
reg		top_q;
wire	pre = cfg_q[1:0] == 2'h1;
wire	sel = cfg_q[1:0] == 2'h2 || pre && cfg_q[11:4] < 8'h02;
always @(posedge CLK_I or posedge RST_I) begin
	if (RST_I) begin
		cfg_q <= 12'h010;
		top_q <= 1'b0;
	end else if (WR_I && ADDR_I == 4'h1) begin
		cfg_q <= WDATA_I[11:0];
	end else if (WR_I && ADDR_I == 4'h0) begin
		top_q <= WDATA_I[1:0] == 2'h1;
	end
end
// =====
// Properties
default clocking @(posedge CLK_I); endclocking
default disable iff (RST_I);
sequence s_act; CONTACT_CLOSED_O == cfg_q[2]; endsequence
property p_rd; !RD_I |=> RDATA_O == 16'h0000; endproperty
a_rd: assert property (p_rd) else $error("stray read data");
property p_pls; LOG_INSTANT_O |=> !LOG_INSTANT_O [*3]; endproperty
a_pls: assert property (p_pls) else $error("log pulse");
property p_rst; disable iff (1'b0) RST_I |-> not s_act; endproperty
a_rst: assert property (p_rst) else $error("reset contact");
property p_off; (!top_q && $stable(cfg_q)) [*3] |-> not s_act; endproperty
a_off: assert property (p_off) else $error("active when off");
property p_trig; $rose(TRIG_I) && top_q |-> ##[1:8] s_act; endproperty
a_trig: assert property (p_trig) else $error("no trigger");
property p_at; LOG_INSTANT_O && top_q && sel |-> s_act; endproperty
a_at: assert property (p_at) else $error("idle at log");
property p_post; LOG_INSTANT_O && top_q && sel && pre |=> s_act; endproperty
a_post: assert property (p_post) else $error("no post hold");
property p_end; LOG_INSTANT_O |-> ##[1:16] CONTACT_CLOSED_O != cfg_q[2];
endproperty
a_end: assert property (p_end) else $error("stuck active");
endmodule // sched_checker
bind log_synced_output_scheduler sched_checker
	#(.SEC_CYCLES(SEC_CYCLES)) chk (
	.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
	.WR_I(WR_I), .RD_I(RD_I), .TRIG_I(TRIG_I), .RDATA_O(RDATA_O),
	.CONTACT_CLOSED_O(CONTACT_CLOSED_O), .LOG_INSTANT_O(LOG_INSTANT_O));
